/* hdl/csirx_defines.vh */
`ifndef CSIRX_DEFINES_VH
`define CSIRX_DEFINES_VH

// register addresses (byte addresses on the plain port)
`define CSIRX_ADDR_MODE      4'h0
`define CSIRX_ADDR_CLKSEL    4'h4
`define CSIRX_ADDR_RXWORD    4'h8
`define CSIRX_ADDR_RXLOW     4'hc
`define CSIRX_ADDR_RXMIRROR  4'h6

// mode register fields
`define CSIRX_MODE_EN        7
`define CSIRX_MODE_TRMD      6
`define CSIRX_MODE_LEN       5
`define CSIRX_MODE_DIR       4
`define CSIRX_MODE_REPEAT    2
`define CSIRX_MODE_BUSY      0

// clock select fields
`define CSIRX_CS_CKP         4
`define CSIRX_CS_DAP         3
`define CSIRX_CS_SEL_HI      2
`define CSIRX_CS_SEL_LO      0
`define CSIRX_SEL_MAX_MASTER 3'h4
`define CSIRX_DIV_W          5
`define CSIRX_LEN8           5'h08
`define CSIRX_LEN16          5'h10

`define CSIRX_MODE_RESET     8'h00
`define CSIRX_CLKSEL_RESET   8'h00
`define CSIRX_RX_RESET       16'h0000

`endif

/* hdl/csirx_top.v */
`timescale 1ns/1ps
`include "csirx_defines.vh"

// half-period enable pulse for the master shift clock
module csirx_clkdiv
#(
	parameter DIV_W = 5
)
(
	// clock and reset
	input  wire       clk_sys,
	input  wire       rstN,
	// control
	input  wire       run,
	input  wire [2:0] sel,
	// enable pulse
	output wire       tick
);

	localparam [DIV_W-1:0] ONE = {{(DIV_W-1){1'b0}}, 1'b1};

	reg  [DIV_W-1:0] div_ff;
	reg  [DIV_W-1:0] nxt_div;
	wire [DIV_W-1:0] divMask;

	// code k toggles every 2^k cycles, a full period of 2^(k+1)
	assign divMask = (ONE << sel) - ONE;
	assign tick    = run && ((div_ff & divMask) == divMask);

	always @*
	begin
		nxt_div = div_ff + ONE;
		if (!run || tick)
			nxt_div = {DIV_W{1'b0}};
	end

	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			div_ff <= {DIV_W{1'b0}};
		else
			div_ff <= nxt_div;
	end

endmodule

// edge finder for the slave shift clock
module csirx_edgedet
(
	// clock and reset
	input  wire clk_sys,
	input  wire rstN,
	// watched level
	input  wire lvl,
	// one-cycle edge pulses
	output wire rise,
	output wire fall
);

	reg lvlD_ff;

	// pin is taken as synchronous, one flop of history is enough
	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			lvlD_ff <= 1'b0;
		else
			lvlD_ff <= lvl;
	end

	assign rise = !lvlD_ff && lvl;
	assign fall = lvlD_ff && !lvl;

endmodule

module csirx_top
(
	// clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// register port
	input  wire [3:0]  regAddr,
	input  wire [15:0] regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [15:0] regRdata,
	// serial link
	input  wire        sckIn,
	output wire        sckOut,
	output wire        sckOe,
	output wire        serialOut,
	input  wire        serialIn,
	// status toward the rest of the channel
	output wire        rxDone
);

	// reset release
	reg  [1:0]  rstSync_ff;
	wire        rstN;

	// software-visible registers
	reg  [7:0]  mode_ff;
	reg  [7:0]  clkSel_ff;
	reg  [15:0] rxBuf_ff;
	reg  [15:0] nxt_rdata;

	// receive engine
	reg  [15:0] shift_ff;
	reg  [15:0] nxt_shift;
	reg  [4:0]  bitCnt_ff;
	reg         sck_ff;
	reg         busy_ff;
	reg         done_ff;
	wire        tick;
	wire        sckRise;
	wire        sckFall;

	// assert at once, release two clean edges later
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rstSync_ff <= 2'h0;
		else
			rstSync_ff <= {rstSync_ff[0], 1'b1};
	end

	assign rstN = rstSync_ff[1];

	// mode and clock select fields
	wire       enable  = mode_ff[`CSIRX_MODE_EN];
	wire       trmd    = mode_ff[`CSIRX_MODE_TRMD];
	wire       len16   = mode_ff[`CSIRX_MODE_LEN];
	wire       lsbFst  = mode_ff[`CSIRX_MODE_DIR];
	wire       repeatM = mode_ff[`CSIRX_MODE_REPEAT];
	wire       ckp     = clkSel_ff[`CSIRX_CS_CKP];
	wire       dap     = clkSel_ff[`CSIRX_CS_DAP];
	wire [2:0] sel     = clkSel_ff[`CSIRX_CS_SEL_HI:`CSIRX_CS_SEL_LO];
	wire       master  = (sel <= `CSIRX_SEL_MAX_MASTER);

	// a disabling write empties the buffers at once, so a read right behind it sees zero
	wire       disWr   = regWr && (regAddr == `CSIRX_ADDR_MODE) && !regWdata[`CSIRX_MODE_EN];
	wire       abort   = !enable || disWr;

	// word and low view start a reception, the mirror never does
	wire       rdWord  = regRd && (regAddr == `CSIRX_ADDR_RXWORD);
	wire       rdLow   = regRd && (regAddr == `CSIRX_ADDR_RXLOW);
	wire       rdStart = enable && !trmd && (rdWord || rdLow);
	wire       start   = rdStart || (repeatM && done_ff && enable);

	csirx_clkdiv
	#(
		.DIV_W (`CSIRX_DIV_W)
	)
	u_clkdiv
	(
		.clk_sys (clk_sys),
		.rstN    (rstN),
		.run     (busy_ff && master),
		.sel     (sel),
		.tick    (tick)
	);

	csirx_edgedet u_sckEdge
	(
		.clk_sys (clk_sys),
		.rstN    (rstN),
		.lvl     (sckIn),
		.rise    (sckRise),
		.fall    (sckFall)
	);

	// ckp chooses the idle level; dap chooses whether the first edge samples or shifts
	wire       lvl      = master ? sck_ff : sckIn;
	wire       edgeA    = master ? (tick && (sck_ff == ckp)) : (ckp ? sckFall : sckRise);
	wire       edgeB    = master ? (tick && (sck_ff != ckp)) : (ckp ? sckRise : sckFall);
	wire       sampEdge = busy_ff && (dap ? edgeB : edgeA);
	wire       shftEdge = busy_ff && (dap ? edgeA : edgeB);
	wire [4:0] lastBit  = len16 ? `CSIRX_LEN16 : `CSIRX_LEN8;

	// late phase: the last sample closes the frame, so no extra clock edge leaks out
	wire       frameEnd = busy_ff && (bitCnt_ff == lastBit) && (dap || shftEdge);

	// mode register, busy bit is read-only
	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			mode_ff <= `CSIRX_MODE_RESET;
		else if (regWr && (regAddr == `CSIRX_ADDR_MODE))
			mode_ff <= {regWdata[7:1], 1'b0};
	end

	// clock select, only safe to change while disabled
	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			clkSel_ff <= `CSIRX_CLKSEL_RESET;
		else if (regWr && (regAddr == `CSIRX_ADDR_CLKSEL))
			clkSel_ff <= regWdata[7:0];
	end

	// frame sequencer
	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			bitCnt_ff <= 5'h00;
			busy_ff   <= 1'b0;
			done_ff   <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			if (abort)
			begin
				bitCnt_ff <= 5'h00;
				busy_ff   <= 1'b0;
			end
			else if (!busy_ff)
			begin
				if (start)
				begin
					busy_ff   <= 1'b1;
					bitCnt_ff <= 5'h00;
				end
			end
			else if (frameEnd)
			begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
			end
			else if (sampEdge)
				bitCnt_ff <= bitCnt_ff + 5'h01;
		end
	end

	// next shift value for either bit order and length
	always @*
	begin
		nxt_shift = shift_ff;
		if (lsbFst && len16)
			nxt_shift = {serialIn, shift_ff[15:1]};
		else if (lsbFst)
			nxt_shift = {8'h00, serialIn, shift_ff[7:1]};
		else
			nxt_shift = {shift_ff[14:0], serialIn};
	end

	// shift register and receive buffer
	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			shift_ff <= `CSIRX_RX_RESET;
			rxBuf_ff <= `CSIRX_RX_RESET;
		end
		else if (abort)
		begin
			shift_ff <= `CSIRX_RX_RESET;
			rxBuf_ff <= `CSIRX_RX_RESET;
		end
		else
		begin
			if (sampEdge && !frameEnd)
				shift_ff <= nxt_shift;
			if (frameEnd)
				rxBuf_ff <= len16 ? shift_ff : {8'h00, shift_ff[7:0]};
		end
	end

	// master shift clock, parked at the idle level outside frames
	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			sck_ff <= 1'b0;
		else if (abort || !busy_ff || frameEnd)
			sck_ff <= ckp;
		else if (tick)
			sck_ff <= ~sck_ff;
	end

	// receive-only: data out idles high; transmit path lives elsewhere
	assign serialOut = 1'b1;
	assign sckOut    = lvl;
	assign sckOe     = enable && master;
	assign rxDone    = done_ff;

	always @*
	begin
		nxt_rdata = 16'h0000;
		case (regAddr)
			`CSIRX_ADDR_MODE:     nxt_rdata = {8'h00, mode_ff[7:1], busy_ff};
			`CSIRX_ADDR_CLKSEL:   nxt_rdata = {8'h00, clkSel_ff};
			`CSIRX_ADDR_RXWORD:   nxt_rdata = rxBuf_ff;
			`CSIRX_ADDR_RXLOW:    nxt_rdata = {8'h00, rxBuf_ff[7:0]};
			`CSIRX_ADDR_RXMIRROR: nxt_rdata = rxBuf_ff;
			default:              nxt_rdata = 16'h0000;
		endcase
	end

	always @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			regRdata <= 16'h0000;
		else if (regRd)
			regRdata <= nxt_rdata;
		else
			regRdata <= 16'h0000;
	end

endmodule

/* verification/csirx_chk.sv */
`timescale 1ns/1ps
module csirx_chk
(
	input wire        clk_sys,
	input wire        arst_n,
	input wire [3:0]  regAddr,
	input wire [15:0] regWdata,
	input wire        regWr,
	input wire        regRd,
	input wire [15:0] regRdata,
	input wire        sckOut,
	input wire        sckOe,
	input wire        rxDone
);
	// shadow of clock select, written on the same edge as the design, so it never lags it even when software breaks the rules
	reg [4:0] cs_ff;
	always @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			cs_ff <= 5'h00;
		else if (regWr && regAddr == 4'h4)
			cs_ff <= regWdata[4:0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
		else $error("read data not idle");
	chk_done_pulse: assert property (rxDone |=> !rxDone)
		else $error("done too long");
	chk_clear_disable: assert property (regWr && regAddr == 4'h0 && !regWdata[7] ##1 regRd && regAddr == 4'h6 |=> regRdata == 16'h0000)
		else $error("buffer kept on disable");
	chk_oe_drop: assert property (regWr && regAddr == 4'h0 && !regWdata[7] |-> ##[1:2] !sckOe)
		else $error("clock still driven");
	chk_toggle_fast: assert property ($rose(sckOut) && sckOe && cs_ff == 5'h00 |=> $fell(sckOut))
		else $error("half rate wrong");
	chk_toggle_quarter: assert property ($rose(sckOut) && sckOe && cs_ff == 5'h01 |=> $stable(sckOut) ##1 $fell(sckOut))
		else $error("quarter rate wrong");
	chk_done_idle: assert property (rxDone && !cs_ff[4] |-> !sckOut)
		else $error("clock not idle low");
	chk_oe_slave: assert property (regWr && regAddr == 4'h4 && regWdata[2:0] > 3'h4 |=> ##1 !sckOe)
		else $error("slave code drives clock");
	cov_done: cover property (rxDone);
	cov_mirror: cover property (regRd && regAddr == 4'h6);
	cov_oe_off: cover property ($fell(sckOe));
endmodule
bind csirx_top csirx_chk u_chk(.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sckOut(sckOut), .sckOe(sckOe), .rxDone(rxDone));

/* verification/csirx_peer.sv */
`timescale 1ns/1ps
module csirx_peer
(
	input wire        sckOut,
	input wire        load,
	input wire [15:0] word,
	output wire       serialIn
);
	reg [15:0] sh;
	// shift after the falling edge so data is steady at the rising sample; fill changes the idle line
	always @(negedge sckOut or posedge load)
		if (load)
			sh <= word;
		else
			sh <= {sh[14:0], ~sh[15]};
	assign serialIn = sh[15];
endmodule

/* verification/csirx_tb.sv */
`timescale 1ns/1ps
module testbench;
	reg         clk_sys = 0;
	reg         arst_n = 0;
	reg  [3:0]  regAddr = 0;
	reg  [15:0] regWdata = 0;
	reg         regWr = 0;
	reg         regRd = 0;
	reg         ld = 0;
	reg  [15:0] w = 0;
	reg  [7:0]  b;
	reg  [31:0] rnd;
	wire [15:0] regRdata;
	wire        sckOut, sckOe, serialOut, serialIn, rxDone;
	integer     fails = 0, comparisons = 0, i, n;
	csirx_top u_dut(.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .sckIn(1'b0), .sckOut(sckOut), .sckOe(sckOe),
		.serialOut(serialOut), .serialIn(serialIn), .rxDone(rxDone));
	csirx_peer u_peer(.sckOut(sckOut), .load(ld), .word(w), .serialIn(serialIn));
	initial forever #50 clk_sys = ~clk_sys;
	task check(input [63:0] nm, input [15:0] seen, input [15:0] exp);
	begin
		comparisons = comparisons + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task final_report;
	begin
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task wr(input [3:0] a, input [15:0] d);
	begin
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		@(posedge clk_sys);
	end
	endtask
	// read data stand only in the cycle after the strobe: look at mid-cycle
	task rd(input [3:0] a, input [15:0] exp, input [63:0] nm);
	begin
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		check(nm, regRdata, exp);
		@(posedge clk_sys);
	end
	endtask
	// peer word is loaded before each start except the last word read, which the disable aborts, so every completed frame carries fresh data
	task arm(input [15:0] d);
	begin
		w <= d;
		ld <= 1'b1;
		@(posedge clk_sys);
		ld <= 1'b0;
	end
	endtask
	task wait_done;
	begin
		n = 0;
		@(negedge clk_sys);
		while (rxDone !== 1'b1 && n < 2000)
		begin
			@(negedge clk_sys);
			n = n + 1;
		end
		@(posedge clk_sys);
		check("done", {15'h0, n < 2000}, 16'h0001);
		if (n >= 2000)
			final_report;
	end
	endtask
	initial
	begin
		rnd = $urandom(32'h365a);
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(4'h6, 16'h0000, "rst");
		check("sout", {15'h0, serialOut}, 16'h0001);
		rnd = $urandom;
		b = rnd[7:0];
		wr(4'h4, {8'h00, b});
		rd(4'h4, {8'h00, b}, "csel");
		for (i = 0; i < 5; i = i + 1)
		begin
			wr(4'h0, 16'h0000);
			wr(4'h4, i[15:0]);
			wr(4'h0, 16'h0080);
			rnd = $urandom;
			b = rnd[7:0];
			arm({b, 8'h00});
			rd(4'hc, 16'h0000, "low0");
			check("oe", {15'h0, sckOe}, 16'h0001);
			wait_done;
			arm({~b, 8'h00});
			rd(4'hc, {8'h00, b}, "low");
			wait_done;
		end
		wr(4'h0, 16'h0000);
		wr(4'h4, 16'h0000);
		wr(4'h0, 16'h00a0);
		rnd = $urandom;
		arm(rnd[15:0]);
		rd(4'h8, 16'h0000, "word0");
		wait_done;
		rd(4'h6, w, "mir");
		rd(4'h0, 16'h00a0, "quiet");
		rd(4'h8, w, "word");
		// disable and read the mirror with no gap between
		regAddr <= 4'h0;
		regWdata <= 16'h0000;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		rd(4'h6, 16'h0000, "clr");
		wr(4'h4, 16'h0005);
		wr(4'h0, 16'h0080);
		@(posedge clk_sys);
		check("slv", {15'h0, sckOe}, 16'h0000);
		final_report;
	end
endmodule
